// ===== hw/act_pkg.sv
// What this block does
// - Trim gain code maps linearly 0.1 dB steps, 0 is -0.8, 8 unity, 15 +0.7
// - Trim gain field sits in bits 7:4 and resets to 8
// - Phase field bits 7:2 delays channel 0..63 modulator cycles, resets to none
// - Scope bits 1:0 pick both, analog only, digital only; 3 reserved
// - Input source bits 7:6: 0 differential, 1 single-ended; host avoids 2 and 3
// - Common-mode tolerance bits 3:2: small, 500 mVpp/1 Vpp, rail-to-rail; 3 reserved
// - Full-scale bit 1: clear 10 Vrms, set 5 Vrms differential; resets clear
// - Bandwidth bit 0: clear 24 kHz, set 96 kHz; host sets only for 40 kOhm
// - Reserved bits read zero; host writes only zero there
// - Phase at 0x54, input at 0x55 reset zero; volume at 0x57 resets 0xa1
// - Volume code 0 mutes, 1 is -80 dB, 0.5 dB steps, 161 is 0 dB
package act_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int          NUM_REGS        = 4;
  localparam logic [7:0]  ADDR_GAIN_TRIM  = 8'h53;
  localparam logic [7:0]  ADDR_PHASE_TRIM = 8'h54;
  localparam logic [7:0]  ADDR_INPUT_CFG  = 8'h55;
  localparam logic [7:0]  ADDR_VOLUME     = 8'h57;
  localparam logic [7:0]  RST_GAIN_TRIM   = 8'h80;
  localparam logic [7:0]  RST_PHASE_TRIM  = 8'h00;
  localparam logic [7:0]  RST_INPUT_CFG   = 8'h00;
  localparam logic [7:0]  RST_VOLUME      = 8'ha1;
  // Writable bits; the rest are reserved and stay zero
  localparam logic [7:0]  WMASK_GAIN_TRIM  = 8'hf0;
  localparam logic [7:0]  WMASK_PHASE_TRIM = 8'hff;
  localparam logic [7:0]  WMASK_INPUT_CFG  = 8'hcf;
  localparam logic [7:0]  WMASK_VOLUME     = 8'hff;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int GAIN_LSB   = 4;
  localparam int DELAY_LSB  = 2;
  localparam int SCOPE_LSB  = 0;
  localparam int INSRC_LSB  = 6;
  localparam int CMTOL_LSB  = 2;
  localparam int FSCALE_BIT = 1;
  localparam int BW_BIT     = 0;
  localparam logic [7:0] VOLUME_MUTE = 8'h00;
  typedef enum logic [1:0] {
    ACT_SCOPE_BOTH = 2'b00,
    ACT_SCOPE_ANA  = 2'b01,
    ACT_SCOPE_DIG  = 2'b10,
    ACT_SCOPE_RSVD = 2'b11
  } act_scope_type;
  // ----------------------------------------
  // Timing and datapath
  // ----------------------------------------
  localparam int CLK_HZ       = 20_000_000;
  localparam int MOD_CLK_HZ   = 2_500_000;
  localparam int MOD_DIV      = CLK_HZ / MOD_CLK_HZ;
  localparam int DELAY_DEPTH  = 64;
  localparam int SAMPLE_W     = 24;
  localparam int COEF_FRAC    = 14;
  // Q2.14 linear factors for -0.8 dB .. +0.7 dB, index is the trim code
  localparam logic [15:0] GAIN_COEF [16] = '{
    16'h3a5e, 16'h3b0b, 16'h3bba, 16'h3c6b, 16'h3d1e, 16'h3dd4, 16'h3e8b, 16'h3f44,
    16'h4000, 16'h40be, 16'h417e, 16'h4240, 16'h4304, 16'h43cb, 16'h4494, 16'h455f
  };
endpackage : act_pkg

// ===== hw/act_path_if.sv
`timescale 1ns/1ns
interface act_delay_if;
  logic       tick;
  logic       bit_in;
  logic       enable;
  logic [5:0] delay;
  logic       bit_out;
  modport ctrl (output tick, bit_in, enable, delay, input bit_out);
  modport line (input tick, bit_in, enable, delay, output bit_out);
endinterface : act_delay_if

interface act_gain_if;
  logic        valid_in;
  logic [23:0] sample_in;
  logic [3:0]  code;
  logic        valid_out;
  logic [23:0] sample_out;
  modport ctrl (output valid_in, sample_in, code, input valid_out, sample_out);
  modport path (input valid_in, sample_in, code, output valid_out, sample_out);
endinterface : act_gain_if

// ===== hw/act_phase_delay.sv
`timescale 1ns/1ns
module act_phase_delay (
  input  wire logic clk,
  input  wire logic resetn,
  act_delay_if.line dif
);
  logic [act_pkg::DELAY_DEPTH-1:0] line_bits;
  logic [act_pkg::DELAY_DEPTH-1:0] next_line_bits;
  logic                            bit_out;
  logic                            next_bit_out;

  // ----------------------------------------
  // Bit history, one entry per modulator cycle
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < act_pkg::DELAY_DEPTH; i++) begin : g_line
      if (i == 0) begin : g_head
        always_comb begin
          next_line_bits[i] = dif.tick ? dif.bit_in : line_bits[i];
        end
      end else begin : g_tail
        // Split so the head entry never names an index below the vector
        always_comb begin
          next_line_bits[i] = dif.tick ? line_bits[i-1] : line_bits[i];
        end
      end
    end
  endgenerate

  always_comb begin
    next_bit_out = bit_out;
    if (dif.tick) begin
      // Disabled path or zero delay passes the current bit
      if (!dif.enable || dif.delay == 6'h00) begin
        next_bit_out = dif.bit_in;
      end else begin
        next_bit_out = line_bits[dif.delay - 6'h01];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      line_bits <= '0;
      bit_out   <= 1'b0;
    end else begin
      line_bits <= next_line_bits;
      bit_out   <= next_bit_out;
    end
  end

  assign dif.bit_out = bit_out;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_zero_delay_pass: assert property ((dif.tick && dif.delay == 6'h00) |=>
    bit_out == $past(dif.bit_in)) else $error("zero delay did not pass bit");
  a_max_delay_tap: assert property ((dif.tick && dif.enable && dif.delay == 6'h3f) |=>
    bit_out == $past(line_bits[62])) else $error("63 cycle tap wrong");
endmodule : act_phase_delay

// ===== hw/act_trim_gain.sv
`timescale 1ns/1ns
module act_trim_gain (
  input  wire logic clk,
  input  wire logic resetn,
  act_gain_if.path  gif
);
  localparam logic signed [40:0] SAT_HI = 41'sh0_0000_7f_ffff;
  localparam logic signed [40:0] SAT_LO = 41'sh1_ffff_80_0000;

  logic [15:0]        coef;
  logic signed [40:0] product;
  logic signed [40:0] scaled;
  logic [23:0]        sample_out;
  logic [23:0]        next_sample_out;
  logic               valid_out;
  logic               next_valid_out;

  // ----------------------------------------
  // Linear scale with saturation
  // ----------------------------------------
  always_comb begin
    coef            = act_pkg::GAIN_COEF[gif.code];
    product         = $signed(gif.sample_in) * $signed({1'b0, coef});
    scaled          = product >>> act_pkg::COEF_FRAC;
    next_valid_out  = gif.valid_in;
    next_sample_out = sample_out;
    if (gif.valid_in) begin
      // Gain above unity can overflow full scale, so clip instead of wrap
      if (scaled > SAT_HI) begin
        next_sample_out = SAT_HI[23:0];
      end else if (scaled < SAT_LO) begin
        next_sample_out = SAT_LO[23:0];
      end else begin
        next_sample_out = scaled[23:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sample_out <= '0;
      valid_out  <= 1'b0;
    end else begin
      sample_out <= next_sample_out;
      valid_out  <= next_valid_out;
    end
  end

  assign gif.sample_out = sample_out;
  assign gif.valid_out  = valid_out;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_unity_gain_pass: assert property ((gif.valid_in && gif.code == 4'h8) |=>
    (valid_out && sample_out == $past(gif.sample_in))) else $error("unity gain changed sample");
endmodule : act_trim_gain

// ===== hw/act_top.sv
`timescale 1ns/1ns
module act_top (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        ch1_ana_mod,
  input  wire logic        ch1_dig_mod,
  output logic             mod_tick,
  output logic             ch1_ana_delayed,
  output logic             ch1_dig_delayed,
  input  wire logic [23:0] ch1_sample,
  input  wire logic        ch1_sample_valid,
  output logic      [23:0] ch1_trimmed,
  output logic             ch1_trimmed_valid,
  output logic      [1:0]  ch2_input_source,
  output logic      [1:0]  ch2_common_mode_tolerance,
  output logic             ch2_full_scale_select,
  output logic             ch2_bandwidth_select,
  output logic      [7:0]  ch2_volume_level,
  output logic             ch2_mute
);
  localparam logic [7:0] REG_ADDR  [act_pkg::NUM_REGS] = '{act_pkg::ADDR_GAIN_TRIM,
    act_pkg::ADDR_PHASE_TRIM, act_pkg::ADDR_INPUT_CFG, act_pkg::ADDR_VOLUME};
  localparam logic [7:0] REG_RST   [act_pkg::NUM_REGS] = '{act_pkg::RST_GAIN_TRIM,
    act_pkg::RST_PHASE_TRIM, act_pkg::RST_INPUT_CFG, act_pkg::RST_VOLUME};
  localparam logic [7:0] REG_WMASK [act_pkg::NUM_REGS] = '{act_pkg::WMASK_GAIN_TRIM,
    act_pkg::WMASK_PHASE_TRIM, act_pkg::WMASK_INPUT_CFG, act_pkg::WMASK_VOLUME};
  localparam int IDX_GAIN  = 0;
  localparam int IDX_PHASE = 1;
  localparam int IDX_INPUT = 2;
  localparam int IDX_VOL   = 3;

  logic [7:0] regs      [act_pkg::NUM_REGS];
  logic [7:0] next_regs [act_pkg::NUM_REGS];
  logic [7:0] next_rdata;
  logic       next_mute;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  genvar r;
  generate
    for (r = 0; r < act_pkg::NUM_REGS; r++) begin : g_reg
      always_comb begin
        next_regs[r] = regs[r];
        if (reg_wr && reg_addr == REG_ADDR[r]) begin
          next_regs[r] = reg_wdata & REG_WMASK[r];
        end
      end
      always_ff @(posedge clk) begin
        if (!resetn) begin
          regs[r] <= REG_RST[r];
        end else begin
          regs[r] <= next_regs[r];
        end
      end
    end
  endgenerate

  always_comb begin
    next_rdata = reg_rdata;
    if (reg_rd) begin
      // Unmapped addresses read as zero
      next_rdata = 8'h00;
      for (int k = 0; k < act_pkg::NUM_REGS; k++) begin
        if (reg_addr == REG_ADDR[k]) begin
          next_rdata = regs[k];
        end
      end
    end
    next_mute = (next_regs[IDX_VOL] == act_pkg::VOLUME_MUTE);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
      ch2_mute  <= 1'b0;
    end else begin
      reg_rdata <= next_rdata;
      ch2_mute  <= next_mute;
    end
  end

  // Channel 2 settings go straight from the register flops
  assign ch2_input_source          = regs[IDX_INPUT][act_pkg::INSRC_LSB +: 2];
  assign ch2_common_mode_tolerance = regs[IDX_INPUT][act_pkg::CMTOL_LSB +: 2];
  assign ch2_full_scale_select     = regs[IDX_INPUT][act_pkg::FSCALE_BIT];
  assign ch2_bandwidth_select      = regs[IDX_INPUT][act_pkg::BW_BIT];
  assign ch2_volume_level          = regs[IDX_VOL];

  // ----------------------------------------
  // Modulator clock enable
  // ----------------------------------------
  logic [7:0] div_count;
  logic [7:0] next_div_count;
  logic       next_mod_tick;

  always_comb begin
    next_mod_tick  = 1'b0;
    next_div_count = div_count + 8'h01;
    if (div_count == 8'(act_pkg::MOD_DIV - 1)) begin
      next_div_count = 8'h00;
      next_mod_tick  = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      div_count <= 8'h00;
      mod_tick  <= 1'b0;
    end else begin
      div_count <= next_div_count;
      mod_tick  <= next_mod_tick;
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] mod_meta;
  logic [1:0] mod_sync;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      mod_meta <= 2'b00;
      mod_sync <= 2'b00;
    end else begin
      mod_meta <= {ch1_dig_mod, ch1_ana_mod};
      mod_sync <= mod_meta;
    end
  end

  // ----------------------------------------
  // Settings taken at the sample boundary
  // ----------------------------------------
  // Changing delay or gain mid-sample would blend two settings into one output word
  logic [3:0]                  act_gain;
  logic [3:0]                  next_act_gain;
  logic [5:0]                  act_delay;
  logic [5:0]                  next_act_delay;
  act_pkg::act_scope_type      act_scope;
  act_pkg::act_scope_type      next_act_scope;

  always_comb begin
    next_act_gain  = act_gain;
    next_act_delay = act_delay;
    next_act_scope = act_scope;
    if (ch1_sample_valid) begin
      next_act_gain  = regs[IDX_GAIN][act_pkg::GAIN_LSB +: 4];
      next_act_delay = regs[IDX_PHASE][act_pkg::DELAY_LSB +: 6];
      next_act_scope = act_pkg::act_scope_type'(regs[IDX_PHASE][act_pkg::SCOPE_LSB +: 2]);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      act_gain  <= act_pkg::RST_GAIN_TRIM[act_pkg::GAIN_LSB +: 4];
      act_delay <= 6'h00;
      act_scope <= act_pkg::ACT_SCOPE_BOTH;
    end else begin
      act_gain  <= next_act_gain;
      act_delay <= next_act_delay;
      act_scope <= next_act_scope;
    end
  end

  // ----------------------------------------
  // Channel 1 delay and trim paths
  // ----------------------------------------
  act_delay_if ana_if ();
  act_delay_if dig_if ();
  act_gain_if  gain_if ();

  logic ana_enable;
  logic dig_enable;

  // Reserved scope code delays neither path
  always_comb begin
    case (act_scope)
      act_pkg::ACT_SCOPE_BOTH: begin
        ana_enable = 1'b1;
        dig_enable = 1'b1;
      end
      act_pkg::ACT_SCOPE_ANA: begin
        ana_enable = 1'b1;
        dig_enable = 1'b0;
      end
      act_pkg::ACT_SCOPE_DIG: begin
        ana_enable = 1'b0;
        dig_enable = 1'b1;
      end
      default: begin
        ana_enable = 1'b0;
        dig_enable = 1'b0;
      end
    endcase
  end

  assign ana_if.tick   = mod_tick;
  assign ana_if.bit_in = mod_sync[0];
  assign ana_if.enable = ana_enable;
  assign ana_if.delay  = act_delay;
  assign dig_if.tick   = mod_tick;
  assign dig_if.bit_in = mod_sync[1];
  assign dig_if.enable = dig_enable;
  assign dig_if.delay  = act_delay;

  assign gain_if.valid_in  = ch1_sample_valid;
  assign gain_if.sample_in = ch1_sample;
  assign gain_if.code      = act_gain;

  act_phase_delay u_ana_delay (.clk(clk), .resetn(resetn), .dif(ana_if));
  act_phase_delay u_dig_delay (.clk(clk), .resetn(resetn), .dif(dig_if));
  act_trim_gain   u_trim_gain (.clk(clk), .resetn(resetn), .gif(gain_if));

  assign ch1_ana_delayed   = ana_if.bit_out;
  assign ch1_dig_delayed   = dig_if.bit_out;
  assign ch1_trimmed       = gain_if.sample_out;
  assign ch1_trimmed_valid = gain_if.valid_out;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_input_write;
    reg_wr && reg_addr == act_pkg::ADDR_INPUT_CFG;
  endsequence
  sequence s_fields_follow;
    ch2_input_source == $past(reg_wdata[7:6]) && ch2_common_mode_tolerance ==
      $past(reg_wdata[3:2]) && ch2_full_scale_select == $past(reg_wdata[1])
      && ch2_bandwidth_select == $past(reg_wdata[0]);
  endsequence
  sequence s_volume_write;
    reg_wr && reg_addr == act_pkg::ADDR_VOLUME;
  endsequence
  sequence s_gain_read;
    reg_rd && reg_addr == act_pkg::ADDR_GAIN_TRIM && !reg_wr;
  endsequence

  // ----------------------------------------
  // Register and path properties
  // ----------------------------------------

  a_reset_values: assert property (@(posedge clk) !resetn |=> (regs[IDX_GAIN] == 8'h80
    && regs[IDX_PHASE] == 8'h00 && regs[IDX_INPUT] == 8'h00 && regs[IDX_VOL] == 8'ha1))
    else $error("register reset value wrong");
  a_rsvd_read_zero: assert property (@(posedge clk) disable iff (!resetn)
    regs[IDX_GAIN][3:0] == 4'h0 && regs[IDX_INPUT][5:4] == 2'b00)
    else $error("reserved bits not zero");
  a_gain_write: assert property (@(posedge clk) disable iff (!resetn)
    (reg_wr && reg_addr == act_pkg::ADDR_GAIN_TRIM) |=> regs[IDX_GAIN][7:4] ==
    $past(reg_wdata[7:4])) else $error("trim gain not written");
  a_input_fields: assert property (@(posedge clk) disable iff (!resetn)
    s_input_write |=> s_fields_follow) else $error("channel 2 fields not written");
  a_phase_readback: assert property (@(posedge clk) disable iff (!resetn)
    (reg_rd && reg_addr == act_pkg::ADDR_PHASE_TRIM && !reg_wr) |=> reg_rdata ==
    $past(regs[IDX_PHASE])) else $error("phase readback wrong");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (!resetn)
    (reg_rd && reg_addr == 8'h56) |=> reg_rdata == 8'h00) else $error("unmapped not zero");
  a_mute_volume: assert property (@(posedge clk) disable iff (!resetn)
    s_volume_write |=> ch2_mute == ($past(reg_wdata) == 8'h00))
    else $error("mute does not follow volume");
  a_boundary_hold: assert property (@(posedge clk) disable iff (!resetn)
    !ch1_sample_valid |=> $stable(act_delay) && $stable(act_gain))
    else $error("trim changed off sample boundary");
  a_trim_latency: assert property (@(posedge clk) disable iff (!resetn)
    ch1_sample_valid |=> ch1_trimmed_valid ##1 !ch1_trimmed_valid || $past(ch1_sample_valid))
    else $error("trimmed sample latency wrong");
  a_tick_period: assert property (@(posedge clk) disable iff (!resetn)
    mod_tick |=> !mod_tick [*7] ##1 mod_tick) else $error("modulator tick period wrong");
  a_volume_write: assert property (@(posedge clk) disable iff (!resetn)
    s_volume_write |=> ch2_volume_level == $past(reg_wdata))
    else $error("volume not written");
  a_gain_readback: assert property (@(posedge clk) disable iff (!resetn)
    s_gain_read |=> reg_rdata == $past(regs[IDX_GAIN]))
    else $error("gain readback wrong");
  a_phase_write: assert property (@(posedge clk) disable iff (!resetn)
    (reg_wr && reg_addr == act_pkg::ADDR_PHASE_TRIM) |=> regs[IDX_PHASE] == $past(reg_wdata))
    else $error("phase trim not written");
  a_rdata_hold: assert property (@(posedge clk) disable iff (!resetn)
    !reg_rd |=> $stable(reg_rdata)) else $error("read data moved without a read");
  a_boundary_take: assert property (@(posedge clk) disable iff (!resetn)
    ch1_sample_valid |=> act_gain == $past(regs[IDX_GAIN][7:4])
    && act_delay == $past(regs[IDX_PHASE][7:2]))
    else $error("settings not taken at boundary");
  a_scope_analog: assert property (@(posedge clk) disable iff (!resetn)
    act_scope == act_pkg::ACT_SCOPE_ANA |-> ana_enable && !dig_enable)
    else $error("analog only scope wrong");
  a_scope_digital: assert property (@(posedge clk) disable iff (!resetn)
    act_scope == act_pkg::ACT_SCOPE_DIG |-> !ana_enable && dig_enable)
    else $error("digital only scope wrong");
  a_scope_reserved: assert property (@(posedge clk) disable iff (!resetn)
    act_scope == act_pkg::ACT_SCOPE_RSVD |-> !ana_enable && !dig_enable)
    else $error("reserved scope delayed a path");
  a_delay_idle: assert property (@(posedge clk) disable iff (!resetn)
    !mod_tick |=> $stable(ch1_ana_delayed) && $stable(ch1_dig_delayed))
    else $error("delayed bit moved between ticks");
  a_meta_to_sync: assert property (@(posedge clk) disable iff (!resetn)
    mod_sync == $past(mod_meta)) else $error("bit synchroniser skipped a stage");
  a_trim_hold: assert property (@(posedge clk) disable iff (!resetn)
    !ch1_sample_valid |=> !ch1_trimmed_valid && $stable(ch1_trimmed))
    else $error("trimmed sample moved without a sample");
endmodule : act_top

// ===== testbench/act_host_model.sv
`timescale 1ns/1ns
module act_host_model (
  input  wire logic       clk,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // Front end assumed at 40 kOhm, so wide band may be chosen
  parameter bit IMP_40K = 1'b1;
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  // ----------------------------------------
  // Host cycles
  // ----------------------------------------
  // Cleans a value the way careful software would
  function automatic logic [7:0] legal(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == 8'h53) v[3:0] = 4'h0;
    if (a == 8'h55) begin
      v[5:4] = 2'b00;
      v[7]   = 1'b0;
      v[0]   = v[0] & IMP_40K;
    end
    return v;
  endfunction : legal
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    // Released lines carry the inverse so stale values never pass
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
  endtask : rd
endmodule : act_host_model

// ===== testbench/test_adc_channel_trim_config.sv
`timescale 1ns/1ns
module test_adc_channel_trim_config;
  logic        clk, resetn, reg_wr, reg_rd;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, ch2_volume_level;
  logic        ch1_ana_mod, ch1_dig_mod, mod_tick, ch1_ana_delayed, ch1_dig_delayed;
  logic [23:0] ch1_sample, ch1_trimmed;
  logic        ch1_sample_valid, ch1_trimmed_valid, ch2_full_scale_select;
  logic [1:0]  ch2_input_source, ch2_common_mode_tolerance;
  logic        ch2_bandwidth_select, ch2_mute;
  int          n_mismatch, total_checks, cycles, age, delay_now;
  bit          chk_bits, seen_tick;
  logic [1:0]  scope_now;
  logic [3:0]  act_code;
  logic [7:0]  shadow [logic [7:0]];
  logic [7:0]  v, a;
  bit          hist_a[$], hist_d[$];
  logic [7:0]  addrs [6] = '{8'h53, 8'h54, 8'h55, 8'h57, 8'h56, 8'h00};
  int          dl [4] = '{0, 1, 63, 17};

  act_host_model u_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  act_top u_dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .ch1_ana_mod(ch1_ana_mod), .ch1_dig_mod(ch1_dig_mod), .mod_tick(mod_tick),
    .ch1_ana_delayed(ch1_ana_delayed), .ch1_dig_delayed(ch1_dig_delayed),
    .ch1_sample(ch1_sample), .ch1_sample_valid(ch1_sample_valid),
    .ch1_trimmed(ch1_trimmed), .ch1_trimmed_valid(ch1_trimmed_valid),
    .ch2_input_source(ch2_input_source), .ch2_common_mode_tolerance(ch2_common_mode_tolerance),
    .ch2_full_scale_select(ch2_full_scale_select), .ch2_bandwidth_select(ch2_bandwidth_select),
    .ch2_volume_level(ch2_volume_level), .ch2_mute(ch2_mute));

  initial clk = 1'b0;
  always #25 clk = ~clk;
  // ----------------------------------------
  // Reporting
  // ----------------------------------------
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  // Run takes about 1700 cycles; a hang is cut well beyond that
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      conclude();
    end
  end
  // ----------------------------------------
  // Expectations
  // ----------------------------------------
  function automatic logic [7:0] mask_of(input logic [7:0] a);
    case (a)
      8'h53: return 8'hf0;
      8'h54, 8'h57: return 8'hff;
      8'h55: return 8'hcf;
      default: return 8'h00;
    endcase
  endfunction : mask_of
  function automatic logic [23:0] exp_trim(input logic [23:0] s, input logic [3:0] c);
    longint p;
    p = (longint'(signed'(s)) * longint'(act_pkg::GAIN_COEF[c])) >>> 14;
    // Saturate rather than wrap, a wrap flips the sign of a loud sample
    if (p > 64'sd8388607) p = 64'sd8388607;
    if (p < -64'sd8388608) p = -64'sd8388608;
    return p[23:0];
  endfunction : exp_trim
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d, input bit clean);
    v = clean ? u_host.legal(a, d) : d;
    u_host.wr(a, v);
    if (shadow.exists(a)) shadow[a] = v & mask_of(a);
  endtask : reg_write
  task automatic reg_check(input logic [7:0] a);
    u_host.rd(a, v);
    check("reg_rdata", v, shadow.exists(a) ? shadow[a] : 8'h00);
  endtask : reg_check
  task automatic check_ch2;
    check("source", ch2_input_source, shadow[8'h55][7:6]);
    check("cm_tol", ch2_common_mode_tolerance, shadow[8'h55][3:2]);
    check("full_scale", ch2_full_scale_select, shadow[8'h55][1]);
    check("bandwidth", ch2_bandwidth_select, shadow[8'h55][0]);
    check("volume", ch2_volume_level, shadow[8'h57]);
    check("mute", ch2_mute, shadow[8'h57] == 8'h00);
  endtask : check_ch2
  task automatic send_sample(input logic [23:0] s);
    @(negedge clk);
    ch1_sample       = s;
    ch1_sample_valid = 1'b1;
    @(negedge clk);
    ch1_sample_valid = 1'b0;
    check("trimmed_valid", ch1_trimmed_valid, 1'b1);
    check("trimmed", ch1_trimmed, exp_trim(s, act_code));
    act_code = shadow[8'h53][7:4];
  endtask : send_sample
  // ----------------------------------------
  // Bitstream monitor
  // ----------------------------------------
  // Pins move four cycles after a tick so capture never sits on a change
  always @(negedge clk) begin
    if (resetn === 1'b1 && mod_tick === 1'b1) begin
      if (seen_tick) check("tick_period", age + 1, 8);
      if (chk_bits && hist_a.size() > 63) begin
        check("ana_delayed", ch1_ana_delayed,
          hist_a[(scope_now == 2'd0 || scope_now == 2'd1) ? delay_now : 0]);
        check("dig_delayed", ch1_dig_delayed,
          hist_d[(scope_now == 2'd0 || scope_now == 2'd2) ? delay_now : 0]);
      end
      hist_a.push_front(ch1_ana_mod);
      hist_d.push_front(ch1_dig_mod);
      if (hist_a.size() > 70) void'(hist_a.pop_back());
      if (hist_d.size() > 70) void'(hist_d.pop_back());
      age       = 0;
      seen_tick = 1'b1;
    end else begin
      age++;
    end
    // Only this process drives the pins, so they are also randomised during reset
    if (age == 4 || resetn !== 1'b1) begin
      ch1_ana_mod = 1'($urandom_range(1));
      ch1_dig_mod = 1'($urandom_range(1));
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    resetn           = 1'b0;
    ch1_sample       = 24'h000000;
    ch1_sample_valid = 1'b0;
    act_code         = 4'h8;
    shadow[8'h53]    = 8'h80;
    shadow[8'h54]    = 8'h00;
    shadow[8'h55]    = 8'h00;
    shadow[8'h57]    = 8'ha1;
    void'($urandom(96024));
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    foreach (addrs[i]) reg_check(addrs[i]);
    check_ch2();
    $display("test reset_values done");
    for (int i = 0; i < 160; i++) begin
      a = addrs[$urandom_range(5)];
      v = 8'($urandom_range(255));
      if (i % 9 == 0) a = 8'($urandom_range(255));
      if (i % 7 == 0) v = 8'h00;
      if (i % 7 == 1) v = 8'h01;
      reg_write(a, v, i[0]);
      reg_check(a);
      check_ch2();
    end
    $display("test register_random done");
    for (int c = 0; c < 16; c++) begin
      reg_write(8'h53, {4'(c), 4'h0}, 1'b1);
      send_sample(24'($urandom));
      send_sample(c > 13 ? (c[0] ? 24'h7fffff : 24'h800000) : 24'($urandom));
    end
    $display("test trim_gain done");
    dl[3] = $urandom_range(62, 2);
    for (int d = 0; d < 4; d++) begin
      for (int s = 0; s < 4; s++) begin
        chk_bits = 1'b0;
        reg_write(8'h54, {6'(dl[d]), 2'(s)}, 1'b0);
        send_sample(24'($urandom));
        delay_now = dl[d];
        scope_now = 2'(s);
        repeat (16) @(negedge clk);
        chk_bits = 1'b1;
        repeat (40) @(negedge clk);
      end
    end
    chk_bits = 1'b0;
    $display("test phase_delay done");
    conclude();
  end
endmodule : test_adc_channel_trim_config
